// [cvb_pkg.sv]
// Shared constants for the delta modulator bit logic
package cvb_pkg;

    // ---------------------------------------------------------------
    // History register lengths
    // ---------------------------------------------------------------
    localparam int HIST_LEN_SHORT = 3;
    localparam int HIST_LEN_LONG = 4;
    localparam int HIST_LEN_MAX = 8;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    // Alternating one-zero idle pattern, newest bit in bit 0
    localparam logic [HIST_LEN_MAX-1:0] HIST_IDLE_PAT = 8'h55;
    // Coincidence output is active low, idle means released
    localparam logic COIN_RST = 1'h1;
    // Newest bit of the idle pattern drives the serial output
    localparam logic DOUT_RST = 1'h1;
    // Bit clock pin idles high between falling edges
    localparam logic BCLK_RST = 1'h1;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CORE_CLK_PERIOD_NS = 5;

endpackage

// [cvb_bit_logic.sv]
// Clocked bit core of a slope delta modulation encoder and decoder
//
// How it works
// R1: Coincidence low when history all ones/zeros.
// R2: History length parameter, three or four bits.
// R3: History advances only on bit clock fall.
// R4: Encode select high captures comparator decision.
// R5: Encode select low captures serial data input.
// R6: Exactly one bit per bit clock period.
// R7: Serial data input inverts onto digital output.
// R8: Output looped to input toggles idle pattern.
// R9: Newest bit drives output and slope polarity.
// R10: Encoder user may inject patterns via select.
// R11: Decoder applies same history and coincidence.
// R12: Digital output updates with history on fall.
// R13: Output low when analog input above feedback.
// R14: Init loads alternating pattern, coincidence released.
module cvb_bit_logic #(
    parameter int HIST_LEN = cvb_pkg::HIST_LEN_SHORT
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic bit_clk,
    input wire logic enc_sel,
    input wire logic cmp_above,
    input wire logic ser_in,
    input wire logic hist_init,
    output logic dig_out_q,
    output logic slope_pol_q,
    output logic coin_b_q,
    output logic bit_stb_q,
    output logic [HIST_LEN-1:0] hist_q
);

    // ---------------------------------------------------------------
    // Local constants
    // ---------------------------------------------------------------
    // Idle pattern cut to the configured length
    localparam logic [HIST_LEN-1:0] HIST_RST = cvb_pkg::HIST_IDLE_PAT[HIST_LEN-1:0];

    // ---------------------------------------------------------------
    // Bit clock edge detection
    // ---------------------------------------------------------------
    logic bclk_prev_q;
    logic bclk_fall;
    logic new_bit;
    logic uniform_d;
    logic [HIST_LEN-1:0] hist_d;

    // Previous level of the bit clock pin
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bclk_prev_q <= cvb_pkg::BCLK_RST;
        end else if (clk_en) begin
            bclk_prev_q <= bit_clk;
        end
    end

    // One strobe per falling edge, so one bit per period
    assign bclk_fall = clk_en && bclk_prev_q && !bit_clk; // R3 R6

    // ---------------------------------------------------------------
    // Source select and sign bit
    // ---------------------------------------------------------------
    // Encode takes comparator, decode or signaling takes data pin
    always_comb begin
        if (enc_sel) begin
            new_bit = !cmp_above; // R4 R13
        end else begin
            new_bit = !ser_in; // R5 R7 R8 R10
        end
    end

    // ---------------------------------------------------------------
    // History shift register
    // ---------------------------------------------------------------
    // Newest bit in bit 0, older bits move up one place
    assign hist_d[0] = new_bit;
    for (genvar i = 1; i < HIST_LEN; i++) begin : g_shift
        assign hist_d[i] = hist_q[i-1]; // R2
    end

    // All ones or all zeros over the whole configured length
    assign uniform_d = (&hist_d) || !(|hist_d); // R1 R2 R11

    // History only moves on a bit clock fall or an init
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hist_q <= HIST_RST;
        end else if (clk_en && hist_init) begin
            hist_q <= HIST_RST; // R14
        end else if (bclk_fall) begin
            hist_q <= hist_d; // R3
        end
    end

    // ---------------------------------------------------------------
    // Serial output and slope polarity
    // ---------------------------------------------------------------
    // Both follow the newest captured bit on the same edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dig_out_q <= cvb_pkg::DOUT_RST;
            slope_pol_q <= cvb_pkg::DOUT_RST;
        end else if (clk_en && hist_init) begin
            dig_out_q <= HIST_RST[0]; // R14
            slope_pol_q <= HIST_RST[0];
        end else if (bclk_fall) begin
            dig_out_q <= new_bit; // R9 R12
            slope_pol_q <= new_bit; // R9
        end
    end

    // ---------------------------------------------------------------
    // Coincidence flag
    // ---------------------------------------------------------------
    // Tracks the history register, low while it is uniform
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            coin_b_q <= cvb_pkg::COIN_RST;
        end else if (clk_en && hist_init) begin
            coin_b_q <= cvb_pkg::COIN_RST; // R14
        end else if (bclk_fall) begin
            coin_b_q <= !uniform_d; // R1 R11
        end
    end

    // ---------------------------------------------------------------
    // Bit strobe
    // ---------------------------------------------------------------
    // One-cycle pulse marking each new bit
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_stb_q <= 1'h0;
        end else if (clk_en) begin
            bit_stb_q <= bclk_fall && !hist_init; // R6
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // Helper view of the current history state
    logic hist_uniform;
    assign hist_uniform = (&hist_q) || !(|hist_q);

    // A capture edge in encode mode
    sequence s_fall_enc;
        bclk_fall && !hist_init && enc_sel;
    endsequence

    // A capture edge in decode mode
    sequence s_fall_dec;
        bclk_fall && !hist_init && !enc_sel;
    endsequence

    // Decode with the output wired back to the data input
    sequence s_loop_fall;
        bclk_fall && !hist_init && !enc_sel && (ser_in == dig_out_q);
    endsequence

    // Flag low exactly while the history is uniform
    a_coin_uniform: assert property ( // R1
        @(posedge core_clk) disable iff (!rst_b)
        coin_b_q == !hist_uniform
    ) else $error("coincidence flag does not match history");

    // No movement of the history without a falling edge or an init
    a_hist_hold: assert property ( // R3
        @(posedge core_clk) disable iff (!rst_b)
        !(clk_en && (bclk_fall || hist_init)) |=> $stable(hist_q)
    ) else $error("history changed without a bit clock fall");

    // Older bits move up by one place on each capture
    a_hist_shift: assert property ( // R2
        @(posedge core_clk) disable iff (!rst_b)
        bclk_fall && !hist_init |=> hist_q[HIST_LEN-1:1] == $past(hist_q[HIST_LEN-2:0])
    ) else $error("history did not shift by one");

    // Encode: output low when the analog input is above feedback
    a_enc_capture: assert property ( // R4
        @(posedge core_clk) disable iff (!rst_b)
        s_fall_enc |=> hist_q[0] == !$past(cmp_above) && dig_out_q == !$past(cmp_above)
    ) else $error("encode capture wrong");

    // Decode: data pin enters inverted
    a_dec_capture: assert property ( // R5
        @(posedge core_clk) disable iff (!rst_b)
        s_fall_dec |=> hist_q[0] == !$past(ser_in) && dig_out_q == !$past(ser_in)
    ) else $error("decode capture wrong");

    // Output and slope polarity both equal the newest history bit
    a_out_newest: assert property ( // R9
        @(posedge core_clk) disable iff (!rst_b)
        dig_out_q == hist_q[0] && slope_pol_q == hist_q[0]
    ) else $error("output or slope polarity differs from newest bit");

    // Output changes only together with a capture or an init
    a_out_on_fall: assert property ( // R12
        @(posedge core_clk) disable iff (!rst_b)
        !$stable(dig_out_q) |-> $past(clk_en && (bclk_fall || hist_init))
    ) else $error("output moved without a bit clock fall");

    // Looped output toggles at every capture
    a_toggle_loop: assert property ( // R8
        @(posedge core_clk) disable iff (!rst_b)
        s_loop_fall |=> dig_out_q != $past(dig_out_q)
    ) else $error("looped output did not toggle");

    // Strobe never lasts two enabled cycles, one bit per period
    a_one_bit: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_b)
        bit_stb_q && clk_en |=> !bit_stb_q
    ) else $error("bit strobe held for two cycles");

    // Strobe follows each capture edge one cycle later
    a_stb_follow: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_b)
        bclk_fall && !hist_init |=> bit_stb_q
    ) else $error("bit strobe missing after capture");

    // Init loads the idle pattern and releases the flag
    a_init_idle: assert property ( // R14
        @(posedge core_clk) disable iff (!rst_b)
        clk_en && hist_init |=> hist_q == HIST_RST && coin_b_q
    ) else $error("init did not load idle pattern");

    // Decoder also asserts coincidence after a uniform run
    a_dec_coin: assert property ( // R11
        @(posedge core_clk) disable iff (!rst_b)
        s_fall_dec ##0 (hist_d == {HIST_LEN{hist_d[0]}}) |=> !coin_b_q
    ) else $error("decoder coincidence missing");

    // History, coincidence flag and bit strobe hold while the clock enable is low
    a_freeze: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !clk_en |=> $stable(hist_q) && $stable(coin_b_q) && $stable(bit_stb_q)
    ) else $error("state moved while clock enable low");

    // Any capture edge, either source
    sequence s_capture;
        bclk_fall && !hist_init;
    endsequence

    // Strobe only rises after a capture edge
    a_stb_source: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_b)
        $rose(bit_stb_q) |-> $past(bclk_fall && !hist_init)
    ) else $error("bit strobe rose without a capture");

    // Two falls never come on adjacent enabled edges
    a_no_double_fall: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_b)
        s_capture |=> !bclk_fall
    ) else $error("two captures back to back");

    // Flag holds between captures
    a_coin_hold: assert property ( // R1
        @(posedge core_clk) disable iff (!rst_b)
        !(clk_en && (bclk_fall || hist_init)) |=> $stable(coin_b_q)
    ) else $error("coincidence flag moved without a capture");

    // Slope polarity holds between captures
    a_slope_hold: assert property ( // R9
        @(posedge core_clk) disable iff (!rst_b)
        !(clk_en && (bclk_fall || hist_init)) |=> $stable(slope_pol_q)
    ) else $error("slope polarity moved without a capture");

    // A mixed history releases the flag
    a_coin_release: assert property ( // R1
        @(posedge core_clk) disable iff (!rst_b)
        s_capture ##0 (hist_d != {HIST_LEN{hist_d[0]}}) |=> coin_b_q
    ) else $error("coincidence flag not released");

    // Encoder asserts coincidence after a uniform run
    a_enc_coin: assert property ( // R1
        @(posedge core_clk) disable iff (!rst_b)
        s_fall_enc ##0 (hist_d == {HIST_LEN{hist_d[0]}}) |=> !coin_b_q
    ) else $error("encoder coincidence missing");

    // Decoder releases the flag on a mixed history
    a_dec_release: assert property ( // R11
        @(posedge core_clk) disable iff (!rst_b)
        s_fall_dec ##0 (hist_d != {HIST_LEN{hist_d[0]}}) |=> coin_b_q
    ) else $error("decoder coincidence not released");

    // Oldest bit takes the one below it on capture
    a_oldest_move: assert property ( // R2
        @(posedge core_clk) disable iff (!rst_b)
        s_capture |=> hist_q[HIST_LEN-1] == $past(hist_q[HIST_LEN-2])
    ) else $error("oldest history bit wrong");

    // Init puts both outputs on the idle level
    a_init_out: assert property ( // R14
        @(posedge core_clk) disable iff (!rst_b)
        clk_en && hist_init |=> dig_out_q == HIST_RST[0] && slope_pol_q == HIST_RST[0]
    ) else $error("init did not set output level");

    // Init suppresses the bit strobe
    a_init_no_stb: assert property ( // R14
        @(posedge core_clk) disable iff (!rst_b)
        clk_en && hist_init |=> !bit_stb_q
    ) else $error("bit strobe after init");

endmodule

// [cvb_far_model.sv]
// Far side model: comparator with integrator loop, and the serial channel
module cvb_far_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bit_stb,
    input wire logic slope_pol,
    input wire logic dig_out,
    input wire logic use_tb,
    input wire logic tb_cmp,
    input wire logic loop_en,
    input wire logic tb_ser,
    input wire logic [7:0] ana_in,
    output logic cmp_above,
    output logic ser_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] integ_q;
    // ---------------------------------------------------------------
    // Integrator: one step per captured bit, direction from slope
    // ---------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            integ_q <= 8'h80;
        end else if (bit_stb) begin
            integ_q <= slope_pol ? integ_q - 8'h04 : integ_q + 8'h04;
        end
    end
    // Comparator, or a level forced by the bench for pattern injection
    assign cmp_above = use_tb ? tb_cmp : (ana_in > integ_q);
    // Channel: output looped back to the data input forms a toggle stage
    assign ser_in = loop_en ? dig_out : tb_ser;
endmodule

// [tb_top.sv]
// Self-checking bench for the delta modulator bit core
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_b, clk_en, bit_clk, enc_sel, cmp_above, ser_in, hist_init;
    logic dig_out_q, slope_pol_q, coin_b_q, bit_stb_q, use_tb, tb_cmp, loop_en, tb_ser;
    logic [3:0] hist_q, exp_hist;
    logic [7:0] ana_in;
    int n_errors = 0;
    int tests_run = 0;
    // ---------------------------------------------------------------
    // Design, long history variant, and far side
    // ---------------------------------------------------------------
    cvb_bit_logic #(.HIST_LEN(4)) uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .bit_clk(bit_clk), .enc_sel(enc_sel), .cmp_above(cmp_above), .ser_in(ser_in),
        .hist_init(hist_init), .dig_out_q(dig_out_q), .slope_pol_q(slope_pol_q),
        .coin_b_q(coin_b_q), .bit_stb_q(bit_stb_q), .hist_q(hist_q));
    cvb_far_model far (.core_clk(core_clk), .rst_b(rst_b), .bit_stb(bit_stb_q),
        .slope_pol(slope_pol_q), .dig_out(dig_out_q), .use_tb(use_tb), .tb_cmp(tb_cmp),
        .loop_en(loop_en), .tb_ser(tb_ser), .ana_in(ana_in), .cmp_above(cmp_above), .ser_in(ser_in));
    // Clock
    initial begin
        core_clk = 1'h0;
        forever #(cvb_pkg::CORE_CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One bit: source v on the selected input, other source opposite; free follows idle toggling
    task automatic step(input logic enc, input logic v, input logic free);
        enc_sel = enc;
        tb_cmp = enc ? v : ~v;
        tb_ser = enc ? ~v : v;
        bit_clk = 1'h1;
        @(negedge core_clk);
        bit_clk = 1'h0;
        @(negedge core_clk);
        exp_hist = {exp_hist[2:0], free ? ~exp_hist[0] : ~v};
        check(hist_q, exp_hist);
        check(dig_out_q, exp_hist[0]);
        check(slope_pol_q, exp_hist[0]);
        check(coin_b_q, !(exp_hist == 4'hf || exp_hist == 4'h0));
        check(bit_stb_q, 1'h1);
        @(negedge core_clk);
        check(bit_stb_q, 1'h0);
    endtask
    task automatic t_track();
        use_tb = 1'h0;
        for (int i = 0; i < 6; i++) begin
            step(1'h1, 1'h0, 1'h1);
        end
        use_tb = 1'h1;
        $display("Test track done");
    endtask
    task automatic t_pattern(input logic enc);
        logic [7:0] pat;
        pat = 8'h1e;
        for (int i = 7; i >= 0; i--) begin
            step(enc, pat[i], 1'h0);
        end
        $display("Test pattern done");
    endtask
    task automatic t_hold();
        clk_en = 1'h0;
        bit_clk = 1'h1;
        repeat (2) @(negedge core_clk);
        bit_clk = 1'h0;
        repeat (4) @(negedge core_clk);
        check(hist_q, exp_hist);
        bit_clk = 1'h1;
        @(negedge core_clk);
        clk_en = 1'h1;
        repeat (3) @(negedge core_clk);
        check(hist_q, exp_hist);
        check(bit_stb_q, 1'h0);
        $display("Test hold done");
    endtask
    task automatic t_loop();
        loop_en = 1'h1;
        for (int i = 0; i < 5; i++) begin
            step(1'h0, 1'h0, 1'h1);
        end
        loop_en = 1'h0;
        $display("Test loop done");
    endtask
    task automatic t_init();
        bit_clk = 1'h1;
        @(negedge core_clk);
        bit_clk = 1'h0;
        hist_init = 1'h1;
        @(negedge core_clk);
        hist_init = 1'h0;
        exp_hist = 4'h5;
        check(hist_q, 4'h5);
        check(coin_b_q, 1'h1);
        check(dig_out_q, 1'h1);
        $display("Test init done");
    endtask
    // Watchdog
    initial begin
        #(cvb_pkg::CORE_CLK_PERIOD_NS * 3000);
        n_errors++;
        results();
    end
    // Main sequence
    initial begin
        rst_b = 1'h0;
        clk_en = 1'h1;
        bit_clk = 1'h1;
        enc_sel = 1'h1;
        hist_init = 1'h0;
        use_tb = 1'h1;
        tb_cmp = 1'h0;
        loop_en = 1'h0;
        tb_ser = 1'h0;
        ana_in = 8'h81;
        exp_hist = 4'h5;
        repeat (3) @(negedge core_clk);
        check(hist_q, 4'h5);
        check(coin_b_q, 1'h1);
        check(bit_stb_q, 1'h0);
        rst_b = 1'h1;
        @(negedge core_clk);
        t_track();
        t_pattern(1'h1);
        t_hold();
        t_pattern(1'h0);
        t_loop();
        t_init();
        step(1'h1, 1'h1, 1'h0);
        results();
    end
endmodule
